// ### rpc_pkg.sv
// shared constants for the serial port control block
package rpc_pkg;

	// ----------------------------------------------------------------
	// register map, one aligned word each, four words per port
	// ----------------------------------------------------------------
	localparam logic [7:0] RPC_PORT_STRIDE = 8'h10;
	localparam logic [1:0] RPC_REG_CFG = 2'h0;
	localparam logic [1:0] RPC_REG_DIV = 2'h1;
	localparam logic [1:0] RPC_REG_TXD = 2'h2;
	localparam logic [1:0] RPC_REG_STAT = 2'h3;

	// ----------------------------------------------------------------
	// configuration word fields
	// ----------------------------------------------------------------
	localparam int RPC_CFG_W = 6;
	localparam int RPC_CLK_LSB = 0;
	localparam int RPC_EN_LSB = 2;
	localparam int RPC_SUPPRESS_BIT = 4;
	localparam int RPC_RTS_BIT = 5;

	// clock_mode_selector encodings
	localparam logic [1:0] RPC_QUARTER_CLOCK_MODE = 2'h0;
	localparam logic [1:0] RPC_HALF_CLOCK_MODE = 2'h1;
	localparam logic [1:0] RPC_FULL_CLOCK_MODE = 2'h2;

	// enable_mode_selector encodings
	localparam logic [1:0] RPC_AUTO_DRIVER_ENABLE = 2'h0;
	localparam logic [1:0] RPC_RTS_DRIVER_ENABLE = 2'h1;
	localparam logic [1:0] RPC_PLAIN_422_MODE = 2'h2;

	// values after reset: quarter clock, automatic enable, echo, rts low
	localparam logic [5:0] RPC_CFG_RESET = 6'h00;
	localparam logic [15:0] RPC_DIV_RESET = 16'h000C;

	// ----------------------------------------------------------------
	// counts
	// ----------------------------------------------------------------
	localparam int RPC_OVERSAMPLE = 16;
	localparam int RPC_FRAME_BITS = 10;

endpackage

// ### rpc_fifo2.sv
// small valid/ready buffer between the register bus and a transmitter
`timescale 1ns/100ps
`default_nettype none

module rpc_fifo2
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready,
	output logic [$clog2(DEPTH+1)-1:0] level
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int LW = $clog2(DEPTH+1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0] wr_q;
	logic [PW-1:0] rd_q;
	logic [LW-1:0] cnt_q;
	wire push = in_valid & in_ready;
	wire pop = out_valid & out_ready;

	// full and empty straight from the count
	assign in_ready = (cnt_q != LW'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rd_q];
	assign level = cnt_q;

	// storage is written only, never reset
	always_ff @(posedge clk)
	begin
		if (push)
			mem_q[wr_q] <= in_data;
	end

	// pointers wrap at the depth
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (push)
				wr_q <= (wr_q == PW'(DEPTH-1)) ? '0 : PW'(wr_q + 1'b1);
			if (pop)
				rd_q <= (rd_q == PW'(DEPTH-1)) ? '0 : PW'(rd_q + 1'b1);
			if (push & ~pop)
				cnt_q <= LW'(cnt_q + 1'b1);
			else if (pop & ~push)
				cnt_q <= LW'(cnt_q - 1'b1);
		end
	end

endmodule

`default_nettype wire

// ### rpc_tx.sv
// per-port prescaler, divisor and character transmitter
`timescale 1ns/100ps
`default_nettype none

module rpc_tx
	import rpc_pkg::*;
#(
	parameter int DIV_W = 16
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [1:0] clk_mode,
	input wire logic [DIV_W-1:0] divisor,
	input wire logic in_valid,
	input wire logic [7:0] in_data,
	output logic in_ready,
	output logic txd,
	output logic busy
);

	typedef enum logic {RPC_IDLE, RPC_SEND} rpc_tx_e;

	logic [1:0] pre_q;
	logic [DIV_W-1:0] div_q;
	logic [3:0] os_q;
	logic [9:0] shift_q;
	logic [3:0] bits_q;
	rpc_tx_e state_q;

	// prescale limit: quarter rate is the default and the reserved code
	wire [1:0] pre_last = (clk_mode == RPC_FULL_CLOCK_MODE) ? 2'h0 :
		(clk_mode == RPC_HALF_CLOCK_MODE) ? 2'h1 : 2'h3;
	wire ref_en = (pre_q >= pre_last);
	wire [DIV_W-1:0] div_last = (divisor == '0) ? '0 : DIV_W'(divisor - 1'b1);
	wire os_en = ref_en & (div_q >= div_last);
	wire bit_en = os_en & (os_q == 4'(RPC_OVERSAMPLE-1));
	wire last_bit = (bits_q == 4'h1);
	wire frame_done = (state_q == RPC_SEND) & bit_en & last_bit;
	wire take = in_valid & bit_en & ((state_q == RPC_IDLE) | last_bit);

	assign in_ready = take;

	// divide chain: prescaler, programmed divisor, oversample count
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pre_q <= '0;
			div_q <= '0;
			os_q <= '0;
		end
		else
		begin
			pre_q <= ref_en ? 2'h0 : 2'(pre_q + 1'b1);
			if (ref_en)
				div_q <= (div_q >= div_last) ? '0 : DIV_W'(div_q + 1'b1);
			if (os_en)
				os_q <= 4'(os_q + 1'b1);
		end
	end

	// shifter: start bit, eight data bits lsb first, stop bit
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= RPC_IDLE;
			shift_q <= '1;
			bits_q <= '0;
			txd <= 1'b1;
			busy <= 1'b0;
		end
		else if (take)
		begin
			state_q <= RPC_SEND;
			shift_q <= {1'b1, in_data, 1'b0};
			bits_q <= 4'(RPC_FRAME_BITS);
			txd <= 1'b0;
			busy <= 1'b1;
		end
		else if (frame_done)
		begin
			state_q <= RPC_IDLE;
			txd <= 1'b1;
			busy <= 1'b0;
		end
		else if ((state_q == RPC_SEND) && bit_en)
		begin
			shift_q <= {1'b1, shift_q[9:1]};
			txd <= shift_q[1];
			bits_q <= 4'(bits_q - 1'b1);
		end
	end

endmodule

`default_nettype wire

// ### rpc_port_ctrl.sv
// four-port rs-485 line control with apb registers and baud prescalers
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - each port prescales the reference clock by four, two or one
// - after reset all ports use quarter clock and automatic driver enable
// - quarter clock with standard divisors gives the usual rates to 115.2k
// - half clock doubles every quarter-clock rate, up to 230.4k
// - full clock gives 460.8k divided by the divisor
// - automatic mode switches the line driver with no software action
// - rts mode drives the line driver from the rts control bit
// - in automatic mode an idle station keeps its driver off the shared line
// - echo mode keeps the receiver on while transmitting
// - outside plain rs-422 mode, suppress turns the receiver off while the driver is on
// - with neither enable selected the driver stays on; only the plain rs-422 code also keeps the receiver on
module rpc_port_ctrl
	import rpc_pkg::*;
#(
	parameter int PORTS = 4,
	parameter int DIV_W = 16,
	parameter int BUF_DEPTH = 2
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [PORTS-1:0] line_txd,
	output logic [PORTS-1:0] line_drv_en,
	output logic [PORTS-1:0] line_rx_en
);

	localparam int LVL_W = $clog2(BUF_DEPTH+1);

	// ----------------------------------------------------------------
	// per-port state
	// ----------------------------------------------------------------
	logic [RPC_CFG_W-1:0] cfg_q [PORTS];
	logic [DIV_W-1:0] div_q [PORTS];
	logic [PORTS-1:0] drv_q;
	logic [PORTS-1:0] rx_q;
	logic [PORTS-1:0] push;
	logic [PORTS-1:0] buf_ready;
	logic [PORTS-1:0] buf_valid;
	logic [PORTS-1:0] tx_take;
	logic [PORTS-1:0] tx_busy;
	logic [PORTS-1:0] tx_line;
	logic [7:0] buf_data [PORTS];
	logic [LVL_W-1:0] buf_level [PORTS];

	// ----------------------------------------------------------------
	// bus state
	// ----------------------------------------------------------------
	logic ready_q;
	logic err_q;
	logic [31:0] rdata_q;

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------

	// the port index sits above the four register words
	wire [3:0] port_idx = paddr[7:4];
	wire [1:0] reg_idx = paddr[3:2];
	wire port_ok = (32'(port_idx) < PORTS) && (paddr[1:0] == 2'h0);
	wire [1:0] psel_idx = port_idx[1:0];
	wire access = psel & penable;
	wire done = access & ready_q;
	wire is_txd = (reg_idx == RPC_REG_TXD);
	wire is_stat = (reg_idx == RPC_REG_STAT);

	// a data write waits while the port buffer is full
	wire stall = port_ok & pwrite & is_txd & ~buf_ready[psel_idx];
	wire answer = access & ~ready_q & ~stall;

	// a write to the status word or a read of the data word is refused
	wire bad = ~port_ok | (pwrite & is_stat) | (~pwrite & is_txd);

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------

	// status word: level, receiver, driver, busy
	function automatic logic [31:0] stat_word(input logic busy_i,
		input logic drv_i, input logic rx_i, input logic [LVL_W-1:0] lvl_i);
		logic [31:0] w;
		w = '0;
		w[LVL_W-1:0] = lvl_i;
		w[8] = rx_i;
		w[9] = drv_i;
		w[10] = busy_i;
		return w;
	endfunction

	logic [31:0] rd_mux;

	// select the addressed word; anything unmapped reads zero
	always_comb
	begin
		rd_mux = '0;
		if (port_ok)
		begin
			case (reg_idx)
				RPC_REG_CFG: rd_mux = 32'(cfg_q[psel_idx]);
				RPC_REG_DIV: rd_mux = 32'(div_q[psel_idx]);
				RPC_REG_STAT: rd_mux = stat_word(tx_busy[psel_idx],
					drv_q[psel_idx], rx_q[psel_idx], buf_level[psel_idx]);
				default: rd_mux = '0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// apb answer
	// ----------------------------------------------------------------

	// ready rises one cycle into the access phase, for one cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ready_q <= 1'b0;
			err_q <= 1'b0;
			rdata_q <= '0;
		end
		else
		begin
			ready_q <= answer;
			err_q <= answer & bad;
			rdata_q <= (answer & ~pwrite & ~bad) ? rd_mux : '0;
		end
	end

	assign pready = ready_q;
	assign pslverr = err_q;
	assign prdata = rdata_q;

	// ----------------------------------------------------------------
	// per-port registers, buffer, transmitter and line enables
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < PORTS; gi++)
		begin : g_port
			wire hit = done & pwrite & ~bad & (32'(port_idx) == gi);
			wire [1:0] mode = cfg_q[gi][RPC_EN_LSB +: 2];
			wire suppress = cfg_q[gi][RPC_SUPPRESS_BIT];
			logic drv_d;
			logic rx_d;

			// each port has its own settings word and divisor
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					cfg_q[gi] <= RPC_CFG_RESET;
					div_q[gi] <= DIV_W'(RPC_DIV_RESET);
				end
				else if (hit)
				begin
					if (reg_idx == RPC_REG_CFG)
						cfg_q[gi] <= pwdata[RPC_CFG_W-1:0];
					if (reg_idx == RPC_REG_DIV)
						div_q[gi] <= pwdata[DIV_W-1:0];
				end
			end

			// a data write completes only when the buffer can take it
			assign push[gi] = hit & is_txd;

			rpc_fifo2 #(
				.WIDTH(8),
				.DEPTH(BUF_DEPTH)
			) u_buf (
				.clk(pclk),
				.rst_n(presetn),
				.in_valid(push[gi]),
				.in_data(pwdata[7:0]),
				.in_ready(buf_ready[gi]),
				.out_valid(buf_valid[gi]),
				.out_data(buf_data[gi]),
				.out_ready(tx_take[gi]),
				.level(buf_level[gi])
			);

			// rate chain: prescale, divisor, oversample
			rpc_tx #(
				.DIV_W(DIV_W)
			) u_tx (
				.clk(pclk),
				.rst_n(presetn),
				.clk_mode(cfg_q[gi][RPC_CLK_LSB +: 2]),
				.divisor(div_q[gi]),
				.in_valid(buf_valid[gi]),
				.in_data(buf_data[gi]),
				.in_ready(tx_take[gi]),
				.txd(tx_line[gi]),
				.busy(tx_busy[gi])
			);

			// driver follows the selected enable source
			always_comb
			begin
				case (mode)
					RPC_AUTO_DRIVER_ENABLE: drv_d = tx_busy[gi];
					RPC_RTS_DRIVER_ENABLE: drv_d = cfg_q[gi][RPC_RTS_BIT];
					default: drv_d = 1'b1;
				endcase
			end

			// receiver stays on for echo and in rs-422 mode
			assign rx_d = (suppress && (mode != RPC_PLAIN_422_MODE)) ?
				~drv_d : 1'b1;

			// registered pin drive
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					drv_q[gi] <= 1'b0;
					rx_q[gi] <= 1'b1;
				end
				else
				begin
					drv_q[gi] <= drv_d;
					rx_q[gi] <= rx_d;
				end
			end
		end
	endgenerate

	assign line_txd = tx_line;
	assign line_drv_en = drv_q;
	assign line_rx_en = rx_q;

endmodule

`default_nettype wire

// ### rpc_port_ctrl_chk.sv
// concurrent checks on the port control block, bound to its ports
`timescale 1ns/100ps
`default_nettype none

module rpc_port_ctrl_chk
	import rpc_pkg::*;
#(
	parameter int PORTS = 4
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [PORTS-1:0] line_txd,
	input wire logic [PORTS-1:0] line_drv_en,
	input wire logic [PORTS-1:0] line_rx_en
);
	// ---------------------------------------------------------
	// mirror of port 0 configuration, taken from the bus
	// ---------------------------------------------------------
	logic [5:0] cfg0_q;
	wire logic cfg0_wr = pready && pwrite && !pslverr && paddr == 8'h00;
	wire logic auto0 = cfg0_q[3:2] == RPC_AUTO_DRIVER_ENABLE;
	wire logic rts0 = cfg0_q[3:2] == RPC_RTS_DRIVER_ENABLE;
	wire logic sup0 = cfg0_q[4] && !cfg0_q[3];

	// follows every accepted write of port 0 configuration
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			cfg0_q <= RPC_CFG_RESET;
		else if (cfg0_wr)
			cfg0_q <= pwdata[5:0];

	// ---------------------------------------------------------
	// properties
	// ---------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence frame_start;
		auto0 && $fell(line_txd[0]);
	endsequence

	pready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held past one cycle");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer cycle");
	bad_addr_a: assert property (pready && (paddr[1:0] != 2'h0 || paddr[7:4] >= PORTS) |-> pslverr)
		else $error("bad address not refused");
	drv_start_a: assert property (frame_start |=> line_drv_en[0])
		else $error("driver late at start bit");
	idle_drv_off_a: assert property (auto0 && !line_drv_en[0] |-> line_txd[0] || $fell(line_txd[0]))
		else $error("line sends with driver off");
	rts_follow_a: assert property (rts0 && $past(rts0) |-> line_drv_en[0] == $past(cfg0_q[5]))
		else $error("driver does not follow rts");
	plain_drv_a: assert property (cfg0_q[3] && $past(cfg0_q[3]) |-> line_drv_en[0])
		else $error("driver off in plain mode");
	suppress_rx_a: assert property (sup0 && $past(sup0) |-> line_rx_en[0] == !line_drv_en[0])
		else $error("receiver on while sending");
	echo_rx_a: assert property (!cfg0_q[4] && $past(!cfg0_q[4]) |-> line_rx_en[0])
		else $error("receiver off in echo mode");
endmodule

bind rpc_port_ctrl rpc_port_ctrl_chk #(.PORTS(PORTS)) u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .line_txd(line_txd),
	.line_drv_en(line_drv_en), .line_rx_en(line_rx_en));
`default_nettype wire

// ### rpc_station.sv
// receiving station on the shared line of one port
`timescale 1ns/100ps
`default_nettype none

module rpc_station
(
	input wire logic clk,
	input wire logic line,
	input wire logic drv_on,
	input wire logic [31:0] bit_cyc,
	output var logic [31:0] got_word,
	output var int n_rx,
	output var int n_bad
);
	logic [7:0] b;

	// ---------------------------------------------------------
	// frame receiver, listens only and never drives the line
	// ---------------------------------------------------------
	initial
	begin
		got_word = 32'h0;
		n_rx = 0;
		n_bad = 0;
		forever
		begin
			@(negedge line);
			repeat (bit_cyc / 2) @(posedge clk);
			if (line !== 1'b0)
				n_bad++;
			for (int i = 0; i < 8; i++)
			begin
				repeat (bit_cyc) @(posedge clk);
				b[i] = line;
			end
			repeat (bit_cyc) @(posedge clk);
			if (line !== 1'b1 || drv_on !== 1'b1)
				n_bad++;
			got_word = {got_word[23:0], b};
			n_rx++;
		end
	end
endmodule
`default_nettype wire

// ### rpc_port_ctrl_test.sv
// self-checking bench for the port control block
`timescale 1ns/100ps
`default_nettype none

module rpc_port_ctrl_test
	import rpc_pkg::*;
;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, got;
	logic pready, pslverr;
	logic [3:0] txd, drv, rx;
	logic [31:0] bit_cyc = 32'd16;
	int n_rx, n_bad;
	int n_fail = 0;
	int num_checks = 0;

	// ---------------------------------------------------------
	// design, far station, clock and watchdog
	// ---------------------------------------------------------
	rpc_port_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .line_txd(txd), .line_drv_en(drv), .line_rx_en(rx));
	rpc_station stn (.clk(pclk), .line(txd[0]), .drv_on(drv[0]), .bit_cyc(bit_cyc),
		.got_word(got), .n_rx(n_rx), .n_bad(n_bad));

	always #20 pclk = ~pclk;

	initial
	begin
		#1000000;
		n_fail++;
		test_done();
	end

	// ---------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------
	task chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
		num_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
		output logic err);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 3000);
		chk("pready", 1'b1, pready);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp,
		input logic xerr);
		logic [31:0] rd;
		logic e;
		apb(w, a, d, rd, e);
		chk("pslverr", xerr, e);
		if (!w)
			chk("prdata", exp, rd);
	endtask

	task wait_rx(input int k);
		int n;
		n = 0;
		while (n_rx < k && n < 9000)
		begin
			@(posedge pclk);
			n++;
		end
		chk("frames", k, n_rx);
		chk("bad frames", 0, n_bad);
		repeat (bit_cyc) @(posedge pclk);
	endtask

	// ---------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------
	task t_reset;
		chk("lines idle", 12'hF0F, {txd, drv, rx});
		for (int p = 0; p < 4; p++)
		begin
			acc(0, 8'(p * 16), 0, 32'(RPC_CFG_RESET), 0);
			acc(0, 8'(p * 16 + 4), 0, 32'(RPC_DIV_RESET), 0);
		end
	endtask

	task t_rates;
		logic [1:0] md[4] = '{RPC_FULL_CLOCK_MODE, RPC_HALF_CLOCK_MODE, RPC_QUARTER_CLOCK_MODE,
			RPC_FULL_CLOCK_MODE};
		int pre[4] = '{1, 2, 4, 1};
		int dv[4] = '{1, 1, 1, 3};
		for (int i = 0; i < 4; i++)
		begin
			bit_cyc = pre[i] * dv[i] * RPC_OVERSAMPLE;
			acc(1, 8'h04, dv[i], 0, 0);
			acc(1, 8'h00, md[i], 0, 0);
			acc(1, 8'h08, 8'hA5 + i, 0, 0);
			wait_rx(i + 1);
			chk("byte", 8'hA5 + i, got[7:0]);
		end
	endtask

	task t_burst;
		for (int i = 1; i <= 3; i++)
			acc(1, 8'h08, 8'h11 * i, 0, 0);
		wait_rx(7);
		chk("burst", 24'h112233, got[23:0]);
	endtask

	task t_echo;
		int n;
		for (int s = 1; s >= 0; s--)
		begin
			acc(1, 8'h00, RPC_FULL_CLOCK_MODE | (s << 4), 0, 0);
			acc(1, 8'h08, 8'h0F, 0, 0);
			n = 0;
			while (drv[0] !== 1'b1 && n < 200)
			begin
				@(posedge pclk);
				n++;
			end
			chk("drv_en sending", 1'b1, drv[0]);
			chk("rx_en sending", !s, rx[0]);
			wait_rx(9 - s);
			chk("drv_en idle", 1'b0, drv[0]);
			chk("rx_en idle", 1'b1, rx[0]);
		end
	endtask

	task t_modes;
		acc(1, 8'h00, 8'h26, 0, 0);
		repeat (3) @(posedge pclk);
		chk("rts high", 1'b1, drv[0]);
		acc(1, 8'h00, 8'h06, 0, 0);
		repeat (3) @(posedge pclk);
		chk("rts low", 1'b0, drv[0]);
		acc(1, 8'h00, 8'h0A, 0, 0);
		acc(1, 8'h10, 8'h08, 0, 0);
		acc(1, 8'h20, 8'h11, 0, 0);
		acc(1, 8'h30, 8'h05, 0, 0);
		repeat (3) @(posedge pclk);
		chk("plain drivers", 4'h3, drv);
		acc(0, 8'h20, 0, 8'h11, 0);
		acc(0, 8'h30, 0, 8'h05, 0);
		acc(1, 8'h00, 8'h02, 0, 0);
		repeat (3) @(posedge pclk);
		chk("port drivers", 4'h2, drv);
	endtask

	task t_refuse;
		acc(0, 8'h40, 0, 0, 1);
		acc(0, 8'h02, 0, 0, 1);
		acc(0, 8'h08, 0, 0, 1);
		acc(1, 8'h0C, 1, 0, 1);
		acc(0, 8'h0C, 0, 32'h00000100, 0);
	endtask

	// ---------------------------------------------------------
	// verdict and main sequence
	// ---------------------------------------------------------
	task test_done;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial
	begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_rates();
		t_burst();
		t_echo();
		t_modes();
		t_refuse();
		test_done();
	end
endmodule
`default_nettype wire
